/* hw/sac_pkg.sv */
// constants shared by the serial audio clock configuration block
package sac_pkg;

   // register offsets
   localparam logic [7:0] OFS_DIR_POL = 8'h09;
   localparam logic [7:0] OFS_DSP_BYTE = 8'h0a;
   localparam logic [7:0] OFS_DIV_RUN = 8'h0c;

   // field positions
   localparam int BIT_POL = 5;
   localparam int BIT_BCK_OE = 4;
   localparam int BIT_LRK_OE = 0;
   localparam int BIT_BCK_RUN = 1;
   localparam int BIT_LRK_RUN = 0;

   // writable bits; all other bits are reserved and read as zero
   localparam logic [7:0] MASK_DIR_POL = 8'h31;
   localparam logic [7:0] MASK_DSP_BYTE = 8'hff;
   localparam logic [7:0] MASK_DIV_RUN = 8'h03;

   // values after reset
   localparam logic [7:0] RST_DIR_POL = 8'h00;
   localparam logic [7:0] RST_DSP_BYTE = 8'h00;
   localparam logic [7:0] RST_DIV_RUN = 8'h00;

   // dsp external control word
   localparam int DSP_CTRL_W = 24;
   localparam int DSP_BYTE_LSB = 8;

   // divider ratio width and smallest usable ratio
   localparam int DIV_W = 8;
   localparam int DIV_MIN = 2;

   // cycles of pin synchroniser latency matched on internal edges
   localparam int SYNC_LAT = 2;

endpackage : sac_pkg

/* hw/sac_edge_if.sv */
// clock level with one-cycle rise and fall enables
`timescale 1ns/1ps
`default_nettype none
interface sac_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport gen (output level, output rise, output fall);
   modport snk (input level, input rise, input fall);
endinterface : sac_edge_if
`default_nettype wire

/* hw/sac_clk_div.sv */
// programmable clock divider with hold-in-reset control
`timescale 1ns/1ps
`default_nettype none
module sac_clk_div #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] ratio,
   sac_edge_if.gen out
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic level;
      logic rise;
      logic fall;
   } sac_div_s;

   sac_div_s st;
   sac_div_s next_st;
   logic [W-1:0] ratio_eff;
   logic [W-1:0] half;

   ////////////////////////////////////////////////////////////////////////
   // ratios below the minimum are raised to it
   assign ratio_eff = (ratio < W'(sac_pkg::DIV_MIN)) ?
                      W'(sac_pkg::DIV_MIN) : ratio;
   assign half = ratio_eff >> 1;

   // counter: high for the first half of the period, low for the rest
   always_comb begin
      next_st = st;
      next_st.rise = 1'b0;
      next_st.fall = 1'b0;
      if (!run) begin
         next_st.cnt = '0;
         next_st.level = 1'b0;
      end else if (tick) begin
         if (st.cnt == ratio_eff - W'(1)) begin
            next_st.cnt = '0;
         end else begin
            next_st.cnt = st.cnt + W'(1);
         end
         if (st.cnt == '0) begin
            next_st.level = 1'b1;
            next_st.rise = 1'b1;
         end else if (st.cnt == half) begin
            next_st.level = 1'b0;
            next_st.fall = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign out.level = st.level;
   assign out.rise = st.rise;
   assign out.fall = st.fall;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_div_held: assert property (@(posedge clock) disable iff (!rstn)
      (!run) [*2] |-> (st.cnt == '0) && !out.level && !out.rise)
      else $error("divider ran while held");

   a_div_restart: assert property (@(posedge clock) disable iff (!rstn)
      $rose(run) && tick && $past(!run) |=> out.rise && out.level)
      else $error("divider did not restart with a rising edge");

   a_div_wrap: assert property (@(posedge clock) disable iff (!rstn)
      run && tick && (st.cnt == ratio_eff - W'(1)) |=> (st.cnt == '0))
      else $error("divider count did not wrap at the ratio");

endmodule : sac_clk_div
`default_nettype wire

/* hw/sac_serial_sampler.sv */
// samples frame clock and serial data on the chosen bit clock edge
`timescale 1ns/1ps
`default_nettype none
module sac_serial_sampler (
   input wire logic clock,
   input wire logic rstn,
   input wire logic invert,
   sac_edge_if.snk serial_bit_clock,
   input wire logic frame_in,
   input wire logic data_in,
   output logic sample_valid,
   output logic sample_data,
   output logic sample_frame,
   output logic frame_start
);

   typedef struct packed {
      logic valid;
      logic data;
      logic frame;
      logic start;
   } sac_smp_s;

   sac_smp_s st;
   sac_smp_s next_st;
   logic strobe;

   ////////////////////////////////////////////////////////////////////////
   // transitions follow one edge, so sample on the opposite one
   assign strobe = invert ? serial_bit_clock.fall : serial_bit_clock.rise;

   always_comb begin
      next_st = st;
      next_st.valid = strobe;
      next_st.start = 1'b0;
      if (strobe) begin
         next_st.data = data_in;
         next_st.frame = frame_in;
         next_st.start = frame_in != st.frame;
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sample_valid = st.valid;
   assign sample_data = st.data;
   assign sample_frame = st.frame;
   assign frame_start = st.start;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_sample_edge: assert property (@(posedge clock) disable iff (!rstn)
      sample_valid |-> $past(invert ? serial_bit_clock.fall : serial_bit_clock.rise))
      else $error("sample taken on the wrong bit clock edge");

   a_frame_start: assert property (@(posedge clock) disable iff (!rstn)
      frame_start |-> sample_valid && (sample_frame != $past(sample_frame)))
      else $error("frame start without a frame clock change");

endmodule : sac_serial_sampler
`default_nettype wire

/* hw/sac_top.sv */
// serial audio port clock configuration: registers, dividers, pins
// Behaviour
// - polarity 1: transitions follow bit clock rise
// - polarity 0 (reset): transitions follow falling edge
// - direction bit: bit clock pin input or output
// - direction bit: frame clock pin input or output
// - master drives clocks; source times data to them
// - master bit clock divides system clock
// - master frame clock divides bit clock
// - control byte feeds dsp control bits 15:8
// - bit clock divider held while run bit 1 is 0
// - frame clock divider held while run bit 0
// - pll off: master clock from system clock
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
   parameter int DW = sac_pkg::DIV_W
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic pll_enable_bit,
   input wire logic pll_tick,
   input wire logic [DW-1:0] bit_clock_div_ratio,
   input wire logic [DW-1:0] frame_clock_div_ratio,
   input wire logic serial_bit_clock_i,
   output logic serial_bit_clock_o,
   output logic serial_bit_clock_oe,
   input wire logic frame_clock_i,
   output logic frame_clock_o,
   output logic frame_clock_oe,
   input wire logic serial_data_in,
   output logic [sac_pkg::DSP_CTRL_W-1:0] dsp_ext_control,
   output logic sample_valid,
   output logic sample_data,
   output logic sample_frame,
   output logic frame_start
);

   typedef struct packed {
      logic [7:0] dir_pol;
      logic [7:0] dsp_byte;
      logic [7:0] div_run;
      logic [7:0] rdata;
      logic bck_s1;
      logic bck_s2;
      logic bck_prev;
      logic lrk_s1;
      logic lrk_s2;
      logic dat_s1;
      logic dat_s2;
      logic [1:0] mrise_d;
      logic [1:0] mfall_d;
      logic [1:0] mlrk_d;
   } sac_top_s;

   sac_top_s st;
   sac_top_s next_st;

   logic bit_clock_polarity_sel;
   logic bit_clock_output_en;
   logic frame_clock_output_en;
   logic bit_clock_divider_run;
   logic frame_clock_divider_run;
   logic master_tick;
   logic frame_tick;

   sac_edge_if bck_if ();
   sac_edge_if lrk_if ();
   sac_edge_if sel_if ();

   ////////////////////////////////////////////////////////////////////////
   // register fields
   assign bit_clock_polarity_sel = st.dir_pol[sac_pkg::BIT_POL];
   assign bit_clock_output_en = st.dir_pol[sac_pkg::BIT_BCK_OE];
   assign frame_clock_output_en = st.dir_pol[sac_pkg::BIT_LRK_OE];
   assign bit_clock_divider_run = st.div_run[sac_pkg::BIT_BCK_RUN];
   assign frame_clock_divider_run = st.div_run[sac_pkg::BIT_LRK_RUN];

   ////////////////////////////////////////////////////////////////////////
   // master clock source: pll output, or the system clock itself
   assign master_tick = pll_enable_bit ? pll_tick : 1'b1;

   // frame clock counts bit clock periods on the transition edge
   assign frame_tick = bit_clock_polarity_sel ? bck_if.rise : bck_if.fall;

   // system clock to bit clock
   sac_clk_div #(.W(DW)) u_bck_div (
      .clock(clock),
      .rstn(rstn),
      .run(bit_clock_divider_run),
      .tick(master_tick),
      .ratio(bit_clock_div_ratio),
      .out(bck_if)
   );

   // bit clock to frame clock
   sac_clk_div #(.W(DW)) u_lrk_div (
      .clock(clock),
      .rstn(rstn),
      .run(frame_clock_divider_run),
      .tick(frame_tick),
      .ratio(frame_clock_div_ratio),
      .out(lrk_if)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin directions and driven levels
   assign serial_bit_clock_oe = bit_clock_output_en;
   assign frame_clock_oe = frame_clock_output_en;
   assign serial_bit_clock_o = bck_if.level;
   assign frame_clock_o = lrk_if.level;

   // edges seen by the sampler: own clock, delayed like the pins, or pin
   assign sel_if.level = bit_clock_output_en ? bck_if.level : st.bck_s2;
   assign sel_if.rise = bit_clock_output_en ?
                        st.mrise_d[1] : (st.bck_s2 & ~st.bck_prev);
   assign sel_if.fall = bit_clock_output_en ?
                        st.mfall_d[1] : (~st.bck_s2 & st.bck_prev);

   // incoming data timed to the chosen clocks
   sac_serial_sampler u_sampler (
      .clock(clock),
      .rstn(rstn),
      .invert(bit_clock_polarity_sel),
      .serial_bit_clock(sel_if),
      .frame_in(frame_clock_output_en ? st.mlrk_d[1] : st.lrk_s2),
      .data_in(st.dat_s2),
      .sample_valid(sample_valid),
      .sample_data(sample_data),
      .sample_frame(sample_frame),
      .frame_start(frame_start)
   );

   // control byte placed into the dsp control word
   assign dsp_ext_control = sac_pkg::DSP_CTRL_W'(st.dsp_byte)
                            << sac_pkg::DSP_BYTE_LSB;
   assign reg_rdata = st.rdata;

   ////////////////////////////////////////////////////////////////////////
   // next state: register writes, reads, synchronisers, delay lines
   always_comb begin
      next_st = st;
      // register writes, reserved bits forced to zero
      if (reg_wr) begin
         unique case (reg_addr)
            sac_pkg::OFS_DIR_POL: begin
               next_st.dir_pol = reg_wdata & sac_pkg::MASK_DIR_POL;
            end
            sac_pkg::OFS_DSP_BYTE: begin
               next_st.dsp_byte = reg_wdata & sac_pkg::MASK_DSP_BYTE;
            end
            sac_pkg::OFS_DIV_RUN: begin
               next_st.div_run = reg_wdata & sac_pkg::MASK_DIV_RUN;
            end
            default: begin
               next_st.dir_pol = st.dir_pol;
            end
         endcase
      end
      // register reads, unmapped offsets answer zero
      if (reg_rd) begin
         unique case (reg_addr)
            sac_pkg::OFS_DIR_POL: begin
               next_st.rdata = st.dir_pol;
            end
            sac_pkg::OFS_DSP_BYTE: begin
               next_st.rdata = st.dsp_byte;
            end
            sac_pkg::OFS_DIV_RUN: begin
               next_st.rdata = st.div_run;
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
      // two-flop synchronisers on the pins
      next_st.bck_s1 = serial_bit_clock_i;
      next_st.bck_s2 = st.bck_s1;
      next_st.bck_prev = st.bck_s2;
      next_st.lrk_s1 = frame_clock_i;
      next_st.lrk_s2 = st.lrk_s1;
      next_st.dat_s1 = serial_data_in;
      next_st.dat_s2 = st.dat_s1;
      // own clock delayed to line up with synchronised data
      next_st.mrise_d = {st.mrise_d[0], bck_if.rise};
      next_st.mfall_d = {st.mfall_d[0], bck_if.fall};
      next_st.mlrk_d = {st.mlrk_d[0], lrk_if.level};
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st <= '{dir_pol: sac_pkg::RST_DIR_POL,
                 dsp_byte: sac_pkg::RST_DSP_BYTE,
                 div_run: sac_pkg::RST_DIV_RUN,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_bck_dir_write: assert property (@(posedge clock) disable iff (!rstn)
      reg_wr && (reg_addr == sac_pkg::OFS_DIR_POL) |=>
      serial_bit_clock_oe == $past(reg_wdata[sac_pkg::BIT_BCK_OE]))
      else $error("bit clock direction did not follow write");

   a_lrk_dir_write: assert property (@(posedge clock) disable iff (!rstn)
      reg_wr && (reg_addr == sac_pkg::OFS_DIR_POL) |=>
      frame_clock_oe == $past(reg_wdata[sac_pkg::BIT_LRK_OE]))
      else $error("frame clock direction did not follow write");

   a_dsp_byte_out: assert property (@(posedge clock) disable iff (!rstn)
      reg_wr && (reg_addr == sac_pkg::OFS_DSP_BYTE) |=>
      dsp_ext_control[15:8] == $past(reg_wdata) &&
      dsp_ext_control[23:16] == 8'h00 && dsp_ext_control[7:0] == 8'h00)
      else $error("dsp control byte not forwarded");

   a_frame_edge: assert property (@(posedge clock) disable iff (!rstn)
      $changed(lrk_if.level) && $past(frame_clock_divider_run) |->
      $past(bit_clock_polarity_sel ? bck_if.rise : bck_if.fall))
      else $error("frame clock moved off the transition edge");

   a_pll_bypass: assert property (@(posedge clock) disable iff (!rstn)
      !pll_enable_bit && bit_clock_divider_run ##1
      bit_clock_divider_run |-> $changed(u_bck_div.st.cnt))
      else $error("divider stalled with pll bypassed");

   a_master_timing: assert property (@(posedge clock) disable iff (!rstn)
      bit_clock_output_en [*3] ##0 sel_if.rise |->
      $past(bck_if.rise, 2))
      else $error("sampler edge not from own bit clock");

   a_reserved_zero: assert property (@(posedge clock) disable iff (!rstn)
      reg_rd && (reg_addr == sac_pkg::OFS_DIV_RUN) |=>
      (reg_rdata & ~sac_pkg::MASK_DIV_RUN) == 8'h00)
      else $error("reserved bits read nonzero");

   ////////////////////////////////////////////////////////////////////////
   // bit clock direction only moves on a write to its register
   a_bck_oe_hold: assert property (@(posedge clock) disable iff (!rstn)
      !(reg_wr && (reg_addr == sac_pkg::OFS_DIR_POL)) |=>
      $stable(serial_bit_clock_oe))
      else $error("bit clock direction changed without write");

   // frame clock direction only moves on a write to its register
   a_lrk_oe_hold: assert property (@(posedge clock) disable iff (!rstn)
      !(reg_wr && (reg_addr == sac_pkg::OFS_DIR_POL)) |=>
      $stable(frame_clock_oe))
      else $error("frame clock direction changed without write");

   // held bit clock divider drives a static low level
   a_bck_pin_low: assert property (@(posedge clock) disable iff (!rstn)
      !bit_clock_divider_run |=> !serial_bit_clock_o)
      else $error("bit clock output moved while held");

   // held frame clock divider drives a static low level
   a_lrk_pin_low: assert property (@(posedge clock) disable iff (!rstn)
      !frame_clock_divider_run |=> !frame_clock_o)
      else $error("frame clock output moved while held");

   // control word only moves on a write to the control byte
   a_dsp_byte_hold: assert property (@(posedge clock) disable iff (!rstn)
      !(reg_wr && (reg_addr == sac_pkg::OFS_DSP_BYTE)) |=>
      $stable(dsp_ext_control))
      else $error("dsp control word changed without write");

   // read data holds until the next read
   a_rdata_hold: assert property (@(posedge clock) disable iff (!rstn)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   // offsets outside the map read as zero
   a_unmapped_read: assert property (@(posedge clock) disable iff (!rstn)
      reg_rd && (reg_addr != sac_pkg::OFS_DIR_POL) &&
      (reg_addr != sac_pkg::OFS_DSP_BYTE) &&
      (reg_addr != sac_pkg::OFS_DIV_RUN) |=> (reg_rdata == 8'h00))
      else $error("unmapped offset read nonzero");

   // polarity select follows the written bit
   a_pol_write: assert property (@(posedge clock) disable iff (!rstn)
      reg_wr && (reg_addr == sac_pkg::OFS_DIR_POL) |=>
      bit_clock_polarity_sel == $past(reg_wdata[sac_pkg::BIT_POL]))
      else $error("polarity select did not follow write");

   // in slave operation the fall edge comes from the synced pin
   a_slave_fall: assert property (@(posedge clock) disable iff (!rstn)
      !bit_clock_output_en [*3] ##0 sel_if.fall |->
      !st.bck_s2 && st.bck_prev)
      else $error("slave fall edge not from the pin");

endmodule : sac_top
`default_nettype wire

/* testbench/sac_src_model.sv */
// external audio source: drives serial data, and the clocks when slave
`timescale 1ns/1ps
`default_nettype none
module sac_src_model (
   input wire logic clock,
   input wire logic run,
   input wire logic master,
   input wire logic invert,
   input wire logic dev_bck,
   input wire logic [7:0] word,
   output logic serial_bit_clock = 1'b1,
   output logic frame = 1'b0,
   output logic data = 1'b0
);
   logic [1:0] div = 2'h0;
   logic [2:0] idx = 3'h0;
   logic last_bck = 1'b0;
   logic launch;
   ////////////////////////////////////////////////////////////////////////
   // launch edge: bit clock fall normally, rise when inverted
   always_comb begin
      if (master)
         launch = (dev_bck != last_bck) && (dev_bck == invert);
      else
         launch = (div == 2'h2) && (serial_bit_clock != invert);
   end
   ////////////////////////////////////////////////////////////////////////
   // own clock stands still while run is low; released data keeps changing
   always @(posedge clock) begin
      last_bck <= dev_bck;
      if (!run) begin
         div <= 2'h0;
         idx <= 3'h0;
         serial_bit_clock <= ~invert;
         data <= ~data;
      end else begin
         div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
         if (!master && div == 2'h2)
            serial_bit_clock <= ~serial_bit_clock;
         if (launch) begin
            data <= word[3'h7 - idx];
            idx <= idx + 3'h1;
            if (idx == 3'h0)
               frame <= ~frame;
         end
      end
   end
endmodule : sac_src_model
`default_nettype wire

/* testbench/serial_audio_clock_config_tb.sv */
// self-checking bench for the serial audio clock configuration block
`timescale 1ns/1ps
`default_nettype none
module serial_audio_clock_config_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic pll_en = 1'b0;
   logic pll_tick = 1'b0;
   logic [7:0] bdiv = 8'h04;
   logic [7:0] fdiv = 8'h04;
   logic bck_o, bck_oe, frm_o, frm_oe, bck_pin, frm_pin;
   logic src_bck, src_frm, src_dat, s_valid, s_data, s_frame, f_start;
   logic [23:0] dsp;
   logic src_run = 1'b0;
   logic src_inv = 1'b0;
   logic [7:0] word = 8'h00;
   int n_mismatch = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock, and a pll enable on every other cycle
   always #50 clock = ~clock;
   always @(posedge clock) pll_tick <= ~pll_tick;
   // pin levels: the device wins while its enable is high
   assign bck_pin = bck_oe ? bck_o : src_bck;
   assign frm_pin = frm_oe ? frm_o : src_frm;
   ////////////////////////////////////////////////////////////////////////
   sac_top sac_top_i (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pll_enable_bit(pll_en), .pll_tick(pll_tick),
      .bit_clock_div_ratio(bdiv), .frame_clock_div_ratio(fdiv),
      .serial_bit_clock_i(bck_pin), .serial_bit_clock_o(bck_o),
      .serial_bit_clock_oe(bck_oe), .frame_clock_i(frm_pin),
      .frame_clock_o(frm_o), .frame_clock_oe(frm_oe),
      .serial_data_in(src_dat), .dsp_ext_control(dsp),
      .sample_valid(s_valid), .sample_data(s_data),
      .sample_frame(s_frame), .frame_start(f_start));
   sac_src_model sac_src_model_i (.clock(clock), .run(src_run),
      .master(bck_oe), .invert(src_inv), .dev_bck(bck_pin), .word(word),
      .serial_bit_clock(src_bck), .frame(src_frm), .data(src_dat));
   ////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // register write and read; effect and read data checked a cycle later
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
      #1;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      #1;
      d = reg_rdata;
   endtask : rd
   // bounded wait for a generated clock level, counting cycles
   task wait_lvl(input bit fr, input logic v, inout int n);
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         #1;
         n++;
         if ((fr ? frm_o : bck_o) === v)
            return;
      end
      n_mismatch++;
      print_verdict;
   endtask : wait_lvl
   task meas(input bit fr, output int hi, output int per);
      int n;
      n = 0;
      wait_lvl(fr, 1'b0, n);
      wait_lvl(fr, 1'b1, n);
      n = 0;
      wait_lvl(fr, 1'b0, n);
      hi = n;
      wait_lvl(fr, 1'b1, n);
      per = n;
   endtask : meas
   // counts cycles in which a generated clock is not low
   task quiet(output int n);
      n = 0;
      repeat (20) begin
         @(posedge clock);
         #1;
         if (bck_o !== 1'b0 || frm_o !== 1'b0)
            n++;
      end
   endtask : quiet
   // gathers sixteen sampled bits and the frame starts among them
   task collect(output logic [15:0] got, output int nfs);
      got = 16'h0000;
      nfs = 0;
      for (int i = 0; i < 16; i++) begin
         int n;
         n = 0;
         while (s_valid !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 200) begin
               n_mismatch++;
               print_verdict;
            end
         end
         got = {got[14:0], s_data};
         if (f_start === 1'b1)
            nfs++;
         @(posedge clock);
         #1;
      end
   endtask : collect
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_regs;
      logic [7:0] d;
      rd(sac_pkg::OFS_DIR_POL, d);
      chk(24'(d), 24'h000000);
      rd(sac_pkg::OFS_DSP_BYTE, d);
      chk(24'(d), 24'h000000);
      rd(sac_pkg::OFS_DIV_RUN, d);
      chk(24'(d), 24'h000000);
      chk(24'({bck_oe, frm_oe}), 24'h000000);
      wr(sac_pkg::OFS_DIR_POL, 8'hff);
      chk(24'({bck_oe, frm_oe}), 24'h000003);
      rd(sac_pkg::OFS_DIR_POL, d);
      chk(24'(d), 24'h000031);
      wr(sac_pkg::OFS_DSP_BYTE, 8'ha5);
      chk(dsp, 24'h00a500);
      rd(sac_pkg::OFS_DSP_BYTE, d);
      chk(24'(d), 24'h0000a5);
      wr(8'h0b, 8'hff);
      rd(8'h0b, d);
      chk(24'(d), 24'h000000);
      wr(sac_pkg::OFS_DIV_RUN, 8'hfc);
      rd(sac_pkg::OFS_DIV_RUN, d);
      chk(24'(d), 24'h000000);
      wr(sac_pkg::OFS_DIR_POL, 8'h00);
      chk(24'({bck_oe, frm_oe}), 24'h000000);
   endtask : t_regs
   task t_div;
      int hi, per, n;
      quiet(n);
      chk(24'(n), 24'h000000);
      wr(sac_pkg::OFS_DIV_RUN, 8'h02);
      n = 0;
      wait_lvl(1'b0, 1'b1, n);
      chk(24'(n <= 3), 24'h000001);
      meas(1'b0, hi, per);
      chk(24'(hi), 24'h000002);
      chk(24'(per), 24'h000004);
      chk(24'(frm_o), 24'h000000);
      wr(sac_pkg::OFS_DIV_RUN, 8'h03);
      meas(1'b1, hi, per);
      chk(24'(per), 24'h000010);
      wr(sac_pkg::OFS_DIV_RUN, 8'h00);
      quiet(n);
      chk(24'(n), 24'h000000);
      @(posedge clock);
      pll_en <= 1'b1;
      wr(sac_pkg::OFS_DIV_RUN, 8'h02);
      meas(1'b0, hi, per);
      chk(24'(per), 24'h000008);
      @(posedge clock);
      pll_en <= 1'b0;
      wr(sac_pkg::OFS_DIV_RUN, 8'h00);
   endtask : t_div
   task t_stream(input bit master, input logic [7:0] cfg, input logic [7:0] w);
      logic [15:0] got;
      int nfs;
      src_inv <= cfg[sac_pkg::BIT_POL];
      repeat (6) @(posedge clock);
      wr(sac_pkg::OFS_DIR_POL, cfg);
      word <= w;
      src_run <= 1'b1;
      if (master)
         wr(sac_pkg::OFS_DIV_RUN, 8'h03);
      collect(got, nfs);
      chk(24'(got), 24'({w, w}));
      if (!master)
         chk(24'(nfs), 24'h000002);
      src_run <= 1'b0;
      wr(sac_pkg::OFS_DIV_RUN, 8'h00);
      repeat (12) @(posedge clock);
   endtask : t_stream
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      t_regs;
      t_div;
      t_stream(1'b0, 8'h00, 8'h96);
      t_stream(1'b0, 8'h20, 8'h5a);
      bdiv <= 8'h08;
      t_stream(1'b1, 8'h31, 8'hc3);
      print_verdict;
   end
endmodule : serial_audio_clock_config_tb
`default_nettype wire
